// ---- logic/psu_diag_regs.svh ----
// Purpose: Register offsets, limits and timing for the diagnostics bank.
// Assumes: A 50 MHz system clock.
// Notes: Definitions only.
`ifndef PSU_DIAG_REGS_SVH
`define PSU_DIAG_REGS_SVH
// --------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------
`define A_OP_HOURS 8'h00
`define A_OP_MIN 8'h04
`define A_TR_ALL 8'h08
`define A_TR_WIN 8'h0c
`define A_VOUT 8'h10
`define A_TURNS 8'h14
`define A_UP_HOURS 8'h18
`define A_UP_MIN 8'h1c
`define A_STATUS 8'h20
`define A_CTRL 8'h24
`define A_SETPT 8'h28
// --------------------------------------------------------------
// Fields, limits and reset values
// --------------------------------------------------------------
`define ST_NVM_OK 0
`define ST_DIP 1
`define ST_GOOD 2
`define ST_BACKFEED 3
`define CTL_SHUT 0
`define MAX_OP_HOURS 19'd262800
`define MAX_MIN 6'd59
`define MAX_COUNT 23'd7200000
`define MAX_UP_HOURS 20'd1000000
`define VOUT_MAX_MV 16'd40000
`define SETPOINT_RST 16'd24100
`define IOUT_NOM_DA 24'd400
`define PHASE_I_DA 16'd200
`define PCT_FULL 24'd100
`define PCT_GOOD 24'd90
`define PCT_PEAK 24'd105
`define TCAP_MAX 16'sd95
`define TAIR_MAX 16'sd65
`define VIN_HI 16'd576
`define VIN_LO 16'd323
`define EVT_N 12
// --------------------------------------------------------------
// Synchronised pin flags
// --------------------------------------------------------------
`define SY_LIMIT 0
`define SY_RESERVE 1
`define SY_PHASE 2
`define SY_HUMID 3
`define SY_LINK 4
`define SY_TRANS 5
`define SY_NVM_OK 6
// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define CLK_KHZ 50000
`define T_REFRESH_MS 50
`define T_DIP_MIN_MS 1
`define T_DIP_HOLD_MS 250
`define T_MINUTE_MS 60000
`endif

// ---- logic/psu_diag_pkg.sv ----
// Purpose: Types shared by the diagnostics bank and its neighbours.
// Assumes: Offsets and limits live in psu_diag_regs.svh.
// Notes: None.
`default_nettype none
package psu_diag_pkg;
  typedef struct packed {
    logic [15:0] vout_mv;
    logic [15:0] iout_da;
    logic signed [15:0] tcap_c;
    logic signed [15:0] tair_c;
    logic [15:0] vin_v;
    logic [18:0] life_hours;
  } meas_t;
  typedef struct packed {
    logic [18:0] hours;
    logic [5:0] minutes;
    logic [22:0] turns;
  } nvm_t;
  typedef enum logic [3:0] {
    ev_output_good, ev_output_dip, ev_peak_power, ev_cap_hot,
    ev_air_hot, ev_overload, ev_vin_high, ev_vin_low,
    ev_supply_down, ev_maintenance, ev_missing_phase, ev_humidity
  } evt_code_t;
  typedef struct packed {
    logic [6:0] s1, s2, s3, flt;
    logic loaded;
    logic [31:0] min_cyc;
    logic [23:0] ref_cyc;
    logic [18:0] op_h;
    logic [5:0] op_m;
    logic [22:0] turns;
    logic [19:0] up_h;
    logic [5:0] up_m;
    logic [22:0] tr_all, tr_win, tr_last;
    logic win_half;
    logic [18:0] sn_op_h;
    logic [5:0] sn_op_m, sn_up_m;
    logic [22:0] sn_all, sn_win, sn_turns;
    logic [19:0] sn_up_h;
    logic [15:0] sn_vout, setpt;
    logic shut;
    logic [23:0] dip_flt, dip_hold;
    logic dip;
    logic [11:0] cond_q, pend;
    logic ev_v;
    evt_code_t ev_code;
    logic [31:0] rdat;
    logic err;
  } state_t;
endpackage
`default_nettype wire

// ---- logic/psu_diag.sv ----
// Purpose: Diagnostic counters, parameters and event source of the supply.
// Assumes: Measurements arrive on clk_sys; flag pins are asynchronous.
// Notes: Registers are reached over APB with one access-phase cycle.
`timescale 1ns/1ps
`default_nettype none
`include "psu_diag_regs.svh"
// --------------------------------------------------------------
// Diagnostics bank
// --------------------------------------------------------------
module psu_diag
  import psu_diag_pkg::*;
#(
  parameter logic [31:0] MINUTE_CYC = 32'(64'(`T_MINUTE_MS) * 64'(`CLK_KHZ)),
  parameter logic [23:0] REF_CYC = 24'(`T_REFRESH_MS * `CLK_KHZ),
  parameter logic [23:0] DIP_MIN_CYC = 24'(`T_DIP_MIN_MS * `CLK_KHZ),
  parameter logic [23:0] DIP_HOLD_CYC = 24'(`T_DIP_HOLD_MS * `CLK_KHZ)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire meas_t meas,
  input wire logic [6:0] flag_pins,
  input wire nvm_t nvm_load,
  output nvm_t nvm_store,
  output logic shutdown,
  output logic output_dip_warning,
  output logic evt_valid,
  output evt_code_t evt_code,
  input wire logic evt_ready
);
  state_t st, n;
  logic tr_rise, min_tick, ref_tick, dip_raw, qualify;
  logic [11:0] cond, clr;
  logic [15:0] vclamp;
  logic [31:0] rd;
  logic rd_err;

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb begin
    n = st;
    clr = '0;
    rd = '0;
    rd_err = 1'b0;
    // Three stages; a level counts once the last two agree.
    n.s1 = flag_pins;
    n.s2 = st.s1;
    n.s3 = st.s2;
    n.flt = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.flt);
    tr_rise = n.flt[`SY_TRANS] & ~st.flt[`SY_TRANS];
    min_tick = (st.min_cyc == MINUTE_CYC - 32'd1);
    ref_tick = (st.ref_cyc == REF_CYC - 24'd1);
    n.min_cyc = min_tick ? '0 : st.min_cyc + 32'd1;
    n.ref_cyc = ref_tick ? '0 : st.ref_cyc + 24'd1;
    vclamp = (meas.vout_mv > `VOUT_MAX_MV) ? `VOUT_MAX_MV : meas.vout_mv;

    // The stored image is taken one cycle after reset, never under it.
    if (!st.loaded) begin
      n.loaded = 1'b1;
      n.op_h = (nvm_load.hours > `MAX_OP_HOURS) ? `MAX_OP_HOURS : nvm_load.hours;
      n.op_m = (nvm_load.minutes > `MAX_MIN) ? '0 : nvm_load.minutes;
      if (nvm_load.turns >= `MAX_COUNT) begin
        n.turns = `MAX_COUNT;
      end else begin
        n.turns = nvm_load.turns + 23'd1;
      end
    end else if (min_tick) begin
      if (st.op_m == `MAX_MIN) begin
        n.op_m = '0;
        if (st.op_h != `MAX_OP_HOURS) begin
          n.op_h = st.op_h + 19'd1;
        end
      end else begin
        n.op_m = st.op_m + 6'd1;
      end
    end
    if (min_tick) begin
      if (st.up_m == `MAX_MIN) begin
        n.up_m = '0;
        if (st.up_h != `MAX_UP_HOURS) begin
          n.up_h = st.up_h + 20'd1;
        end
      end else begin
        n.up_m = st.up_m + 6'd1;
      end
    end

    if (tr_rise && st.tr_all != `MAX_COUNT) begin
      n.tr_all = st.tr_all + 23'd1;
    end
    // The published window count is the last completed two minutes.
    if (min_tick) begin
      n.win_half = ~st.win_half;
    end
    if (min_tick && st.win_half) begin
      n.tr_last = st.tr_win;
      n.tr_win = {22'd0, tr_rise};
    end else if (tr_rise && st.tr_win != `MAX_COUNT) begin
      n.tr_win = st.tr_win + 23'd1;
    end

    // Dip filter and stretcher.
    dip_raw = 24'(vclamp) * `PCT_FULL < 24'(st.setpt) * `PCT_GOOD;
    if (!dip_raw) begin
      n.dip_flt = '0;
    end else if (st.dip_flt < DIP_MIN_CYC - 24'd1) begin
      n.dip_flt = st.dip_flt + 24'd1;
    end
    qualify = dip_raw && (st.dip_flt == DIP_MIN_CYC - 24'd1);
    if (qualify) begin
      n.dip_hold = DIP_HOLD_CYC;
    end else if (st.dip_hold != '0) begin
      n.dip_hold = st.dip_hold - 24'd1;
    end
    n.dip = (n.dip_hold != '0);

    cond[ev_output_good] = 24'(vclamp) * `PCT_FULL >= 24'(st.setpt) * `PCT_GOOD;
    cond[ev_output_dip] = st.dip;
    cond[ev_peak_power] = st.flt[`SY_RESERVE]
      && 24'(meas.iout_da) * `PCT_FULL > `IOUT_NOM_DA * `PCT_PEAK;
    cond[ev_cap_hot] = meas.tcap_c > `TCAP_MAX;
    cond[ev_air_hot] = meas.tair_c > `TAIR_MAX;
    cond[ev_overload] = st.flt[`SY_LIMIT];
    cond[ev_vin_high] = meas.vin_v > `VIN_HI;
    cond[ev_vin_low] = meas.vin_v < `VIN_LO;
    cond[ev_supply_down] = ~st.flt[`SY_LINK];
    cond[ev_maintenance] = st.op_h > meas.life_hours;
    cond[ev_missing_phase] = st.flt[`SY_PHASE] && meas.iout_da > `PHASE_I_DA;
    cond[ev_humidity] = st.flt[`SY_HUMID];

    // Publish values and sample conditions on the refresh tick.
    if (ref_tick) begin
      n.sn_op_h = st.op_h;
      n.sn_op_m = st.op_m;
      n.sn_all = st.tr_all;
      n.sn_win = st.tr_last;
      n.sn_turns = st.turns;
      n.sn_up_h = st.up_h;
      n.sn_up_m = st.up_m;
      n.sn_vout = vclamp;
      n.cond_q = cond;
    end

    // Lowest code wins; a new rise beats the clear of the same bit.
    if (!st.ev_v || evt_ready) begin
      n.ev_v = 1'b0;
      for (int i = `EVT_N - 1; i >= 0; i--) begin
        if (st.pend[i]) begin
          n.ev_v = 1'b1;
          n.ev_code = evt_code_t'(4'(i));
          clr = 12'd1 << i;
        end
      end
    end
    n.pend = (st.pend & ~clr) | (ref_tick ? (cond & ~st.cond_q) : 12'd0);

    unique case (paddr)
      `A_OP_HOURS: rd = 32'(st.sn_op_h);
      `A_OP_MIN: rd = 32'(st.sn_op_m);
      `A_TR_ALL: rd = 32'(st.sn_all);
      `A_TR_WIN: rd = 32'(st.sn_win);
      `A_VOUT: rd = 32'(st.sn_vout);
      `A_TURNS: rd = 32'(st.sn_turns);
      `A_UP_HOURS: rd = 32'(st.sn_up_h);
      `A_UP_MIN: rd = 32'(st.sn_up_m);
      `A_STATUS: begin
        rd[`ST_NVM_OK] = st.flt[`SY_NVM_OK];
        rd[`ST_DIP] = st.dip;
        rd[`ST_GOOD] = st.cond_q[ev_output_good];
        rd[`ST_BACKFEED] = st.sn_vout > st.setpt;
      end
      `A_CTRL: rd[`CTL_SHUT] = st.shut;
      `A_SETPT: rd = 32'(st.setpt);
      default: rd_err = 1'b1;
    endcase
    // Read data is latched in setup so the bus sees a flop.
    if (psel && !penable) begin
      n.rdat = rd_err ? 32'h0 : rd;
      n.err = rd_err;
    end
    if (psel && penable && pwrite && paddr == `A_CTRL) begin
      n.shut = pwdata[`CTL_SHUT];
    end
    if (psel && penable && pwrite && paddr == `A_SETPT) begin
      n.setpt = pwdata[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.setpt <= `SETPOINT_RST;
    end else begin
      st <= n;
    end
  end

  assign prdata = st.rdat;
  assign pready = psel & penable;
  assign pslverr = psel & penable & st.err;
  assign nvm_store = '{hours: st.op_h, minutes: st.op_m, turns: st.turns};
  assign shutdown = st.shut;
  assign output_dip_warning = st.dip;
  assign evt_valid = st.ev_v;
  assign evt_code = st.ev_code;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  op_hour_wrap_a: assert property (st.loaded && min_tick && st.op_m == `MAX_MIN
    && st.op_h < `MAX_OP_HOURS |=> st.op_h == $past(st.op_h) + 19'd1 && st.op_m == '0)
    else $error("Operating hours did not advance.");
  tr_count_a: assert property (st.loaded && tr_rise && st.tr_all < `MAX_COUNT
    |=> st.tr_all == $past(st.tr_all) + 23'd1)
    else $error("Transient total missed an edge.");
  win_bound_a: assert property (st.tr_win <= `MAX_COUNT && st.sn_win <= `MAX_COUNT)
    else $error("Window count passed its bound.");
  vout_clamp_a: assert property (st.sn_vout <= `VOUT_MAX_MV)
    else $error("Published voltage above range.");
  turns_once_a: assert property (st.loaded |=> st.loaded && $stable(st.turns))
    else $error("Turn-on counter moved after boot.");
  up_min_step_a: assert property (min_tick && st.up_m < `MAX_MIN
    |=> st.up_m == $past(st.up_m) + 6'd1)
    else $error("Uptime minutes did not step.");
  nvm_bit_a: assert property (psel && !penable && paddr == `A_STATUS
    |=> prdata[`ST_NVM_OK] == $past(st.flt[`SY_NVM_OK]))
    else $error("Memory health bit misreported.");
  shut_write_a: assert property (psel && penable && pwrite && paddr == `A_CTRL
    |=> shutdown == $past(pwdata[`CTL_SHUT]))
    else $error("Shut-down bit did not follow write.");
  good_event_a: assert property (ref_tick && cond[ev_output_good]
    && !st.cond_q[ev_output_good] |=> st.pend[ev_output_good])
    else $error("Output-good rise not queued.");
  dip_hold_a: assert property ($fell(output_dip_warning) |-> $past(st.dip_hold) == 24'd1)
    else $error("Dip warning ended early.");
  dip_filter_a: assert property ($rose(output_dip_warning)
    |-> $past(st.dip_flt) == DIP_MIN_CYC - 24'd1 && $past(dip_raw))
    else $error("Short dip was not filtered.");
  snap_hold_a: assert property (!$past(ref_tick) |-> $stable(st.sn_op_h)
    && $stable(st.cond_q))
    else $error("Published value changed off tick.");

  dip_seen_c: cover property ($rose(output_dip_warning));
  evt_taken_c: cover property (evt_valid && evt_ready);
  shut_on_c: cover property ($rose(shutdown));
endmodule // psu_diag
`default_nettype wire

// ---- dv/psu_diag_host.sv ----
// Purpose: Event sink that stands in for the link master on the far side.
// Assumes: Event codes stay below twelve.
// Notes: Slow mode withholds ready on every other cycle to stall the source.
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// Event sink
// --------------------------------------------------------------
module psu_diag_host
  import psu_diag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic slow,
  input wire logic evt_valid,
  input wire evt_code_t evt_code,
  output logic evt_ready,
  output logic [11:0] seen,
  output logic [7:0] total
);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      evt_ready <= 1'b0;
      seen <= 12'h000;
      total <= 8'h00;
    end else begin
      evt_ready <= slow ? ~evt_ready : 1'b1;
      if (evt_valid && evt_ready) begin
        // The device keeps no history, so every accepted code is logged here.
        seen[evt_code] <= 1'b1;
        total <= total + 8'h01;
      end
    end
  end
endmodule // psu_diag_host
`default_nettype wire

// ---- dv/psu_diag_test.sv ----
// Purpose: Self-checking bench for the diagnostics bank over APB.
// Assumes: Shortened minute, refresh and dip timings set below.
// Notes: Window reads are timed so the pulses fall in the first window.
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// Bench
// --------------------------------------------------------------
module psu_diag_test
  import psu_diag_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  meas_t meas = '{16'h5e24, 16'h0064, 16'h0019, 16'h0019, 16'h0190, 19'h3ffff};
  logic [6:0] flag_pins = 7'h50;
  nvm_t nvm_load = '{19'h4028f, 6'h3b, 23'h000005};
  nvm_t nvm_store;
  logic shutdown;
  logic output_dip_warning;
  logic evt_valid;
  evt_code_t evt_code;
  logic evt_ready;
  logic slow = 1'b0;
  logic [11:0] seen;
  logic [7:0] total;
  logic [7:0] held;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;

  psu_diag #(.MINUTE_CYC(32'hc8), .REF_CYC(24'h14), .DIP_MIN_CYC(24'h5),
    .DIP_HOLD_CYC(24'h28)) dut (.clk_sys(clk_sys), .reset(reset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
    .flag_pins(flag_pins), .nvm_load(nvm_load), .nvm_store(nvm_store),
    .shutdown(shutdown), .output_dip_warning(output_dip_warning),
    .evt_valid(evt_valid), .evt_code(evt_code), .evt_ready(evt_ready));
  psu_diag_host host (.clk_sys(clk_sys), .reset(reset), .slow(slow),
    .evt_valid(evt_valid), .evt_code(evt_code), .evt_ready(evt_ready),
    .seen(seen), .total(total));

  always #10 clk_sys = ~clk_sys;

  // The cycle count doubles as the hang guard; the whole run needs about 12300.
  always @(posedge clk_sys) begin
    cyc <= reset ? 0 : cyc + 1;
    if (cyc == 15000) begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, s, x);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, x);
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic wait_cyc(input int n);
    while (cyc < n) @(posedge clk_sys);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      repeat (4) @(posedge clk_sys);
      flag_pins[5] <= ~flag_pins[5];
    end
    wait_cyc(260);
    apb(1'b1, 8'h00, 32'h1, rd, err);
    rdchk(8'h00, 32'h40290);
    rdchk(8'h04, 32'h0);
    rdchk(8'h14, 32'h6);
    rdchk(8'h1c, 32'h1);
    rdchk(8'h18, 32'h0);
    chk(32'(nvm_store.hours), 32'h40290);
    chk(32'(nvm_store.minutes), 32'h0);
    chk(32'(nvm_store.turns), 32'h6);
    rdchk(8'h20, 32'h5);
    apb(1'b0, 8'h2c, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h24, 32'h1, rd, err);
    rdchk(8'h24, 32'h1);
    chk({31'h0, shutdown}, 32'h1);
    apb(1'b1, 8'h24, 32'h0, rd, err);
    rdchk(8'h24, 32'h0);
    chk({31'h0, shutdown}, 32'h0);
    rdchk(8'h28, 32'h5e24);
    wait_cyc(460);
    rdchk(8'h08, 32'h3);
    rdchk(8'h0c, 32'h3);
    meas.vout_mv <= 16'hafc8;
    wait_cyc(520);
    rdchk(8'h10, 32'h9c40);
    rdchk(8'h20, 32'hd);
    meas.vout_mv <= 16'h4e20;
    repeat (3) @(posedge clk_sys);
    meas.vout_mv <= 16'h5e24;
    repeat (10) @(posedge clk_sys);
    chk({31'h0, output_dip_warning}, 32'h0);
    meas.vout_mv <= 16'h4e20;
    repeat (12) @(posedge clk_sys);
    chk({31'h0, output_dip_warning}, 32'h1);
    meas.vout_mv <= 16'h5e24;
    repeat (30) @(posedge clk_sys);
    chk({31'h0, output_dip_warning}, 32'h1);
    repeat (30) @(posedge clk_sys);
    chk({31'h0, output_dip_warning}, 32'h0);
    // Every remaining event source but low input is raised at once while the sink stalls; low input follows 80 cycles later.
    slow <= 1'b1;
    flag_pins <= 7'h4f;
    meas.iout_da <= 16'h01f4;
    meas.tcap_c <= 16'h0060;
    meas.tair_c <= 16'h0042;
    meas.vin_v <= 16'h0258;
    repeat (80) @(posedge clk_sys);
    meas.vin_v <= 16'h012c;
    repeat (80) @(posedge clk_sys);
    chk({20'h0, seen}, 32'hfff);
    held = total;
    repeat (120) @(posedge clk_sys);
    chk({24'h0, total}, {24'h0, held});
    // The second window saw no transients, while the lifetime total keeps them.
    wait_cyc(840);
    rdchk(8'h0c, 32'h0);
    rdchk(8'h08, 32'h3);
    // After sixty more minutes the hours stay saturated and uptime reaches one hour.
    wait_cyc(12300);
    rdchk(8'h00, 32'h40290);
    rdchk(8'h04, 32'h0);
    rdchk(8'h18, 32'h1);
    rdchk(8'h1c, 32'h1);
    chk({24'h0, total}, {24'h0, held});
    results();
  end
endmodule // psu_diag_test
`default_nettype wire
